// [logic/tpr_debounce.sv]
// Debounce filter for one synchronised level.
// Assumes the input is already on the clock domain of this module.
`timescale 1ns/1ps
module tpr_debounce #(
  parameter int unsigned CYCLES = 2500
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Level in and filtered level out
  input wire logic level_in,
  output logic level_q
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_q;

  // The output follows only after the input has differed for CYCLES edges.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      level_q <= 1'b0;
    end
    else if (level_in == level_q)
    begin
      count_q <= '0;
    end
    else if (count_q == LAST)
    begin
      count_q <= '0;
      level_q <= level_in;
    end
    else
    begin
      count_q <= count_q + CW'(1);
    end
  end

endmodule

// [logic/tpr_pkg.sv]
// Constants, register map and state types of the touch panel readout block.
// Assumes a single system clock at the rate given by CLK_MHZ.
package tpr_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 250;
  // Least time the detect level must hold before the debounced copy follows.
  localparam int unsigned DEBOUNCE_NS = 10000;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  // Least settle time per step of the sample time field before a conversion.
  localparam int unsigned SETTLE_UNIT_NS = 1000;
  localparam int unsigned SETTLE_UNIT_CYC = (SETTLE_UNIT_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_ENABLE_CTRL = 8'h70;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h71;
  localparam logic [7:0] IDX_X_HIGH = 8'h72;
  localparam logic [7:0] IDX_Y_HIGH = 8'h73;
  localparam logic [7:0] IDX_XY_LOW = 8'h74;
  localparam logic [7:0] IDX_STATUS = 8'h75;
  localparam logic [7:0] IDX_INT_EN = 8'hF0;
  localparam logic [7:0] IDX_INT_STAT = 8'hF1;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned SETTLE_LSB = 4;
  localparam int unsigned MANUAL_BIT = 6;
  localparam int unsigned DEBOUNCE_EN_BIT = 2;
  localparam int unsigned STATE_LSB = 0;
  localparam int unsigned STATUS_TOUCH_BIT = 5;
  localparam int unsigned LOW_TOUCH_BIT = 7;
  localparam int unsigned LOW_Y_LSB = 2;
  localparam int unsigned LOW_X_LSB = 0;
  localparam int unsigned INT_TOUCH_EN_BIT = 6;
  localparam int unsigned INT_TOUCH_BIT = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] ENABLE_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [9:0] COORD_RST = 10'h000;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Controller states; the manual state field selects them in this order.
  typedef enum logic [1:0] {TPR_IDLE, TPR_CHECK, TPR_LATCH_X, TPR_LATCH_Y} tpr_state_t;
  // Conversion steps inside a latch state.
  typedef enum logic [1:0] {TPR_CV_SETTLE, TPR_CV_BUSY, TPR_CV_DONE} tpr_conv_t;

endpackage

// [logic/tpr_top.sv]
// Touch panel readout controller with an APB register slave.
// Assumes a 10-bit ADC on the same clock that converts the selected axis on
// a start pulse and answers with a one-cycle done pulse; the touch detect
// level arrives from a pin and is synchronised here.
`timescale 1ns/1ps

module tpr_top #(
  parameter int unsigned DEBOUNCE_CYCLES = tpr_pkg::DEBOUNCE_CYC,
  parameter int unsigned SETTLE_CYCLES = tpr_pkg::SETTLE_UNIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Touch detect pin
  input wire logic touch_detect_signal,
  // ADC front end
  output logic adc_start,
  output logic adc_sel_y,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] enable_ctrl_q;
  logic [7:0] mode_ctrl_q;
  logic [7:0] int_en_q;
  logic touch_flag_q;
  logic [9:0] x_coord_q;
  logic [9:0] y_coord_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic adc_start_q;
  logic adc_sel_y_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic touch_raw_q;
  logic touch_deb;
  logic touch_det;
  logic touch_det_prev_q;
  tpr_pkg::tpr_state_t state_q;
  tpr_pkg::tpr_state_t state_d;
  tpr_pkg::tpr_state_t last_state_q;
  tpr_pkg::tpr_conv_t conv_q;
  logic [11:0] settle_q;
  logic [11:0] settle_load;
  logic active;
  logic manual;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] rd_byte;
  logic auto_done;
  logic touch_event;
  logic flag_clear;

  // ==========================================================================
  // Register access decode
  // ==========================================================================
  // A transfer is taken at the edge where pready is seen high in access phase.
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign idx = paddr[9:2];
  assign active = enable_ctrl_q[tpr_pkg::ENABLE_BIT];
  assign manual = mode_ctrl_q[tpr_pkg::MANUAL_BIT];

  // Address decode covers every mapped index on a word boundary.
  always_comb
  begin
    mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    case (idx)
      tpr_pkg::IDX_ENABLE_CTRL,
      tpr_pkg::IDX_MODE_CTRL,
      tpr_pkg::IDX_X_HIGH,
      tpr_pkg::IDX_Y_HIGH,
      tpr_pkg::IDX_XY_LOW,
      tpr_pkg::IDX_STATUS,
      tpr_pkg::IDX_INT_EN,
      tpr_pkg::IDX_INT_STAT: mapped = mapped;
      default: mapped = 1'b0;
    endcase
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx)
      tpr_pkg::IDX_ENABLE_CTRL: rd_byte = enable_ctrl_q;
      tpr_pkg::IDX_MODE_CTRL: rd_byte = mode_ctrl_q;
      tpr_pkg::IDX_X_HIGH: rd_byte = x_coord_q[9:2];
      tpr_pkg::IDX_Y_HIGH: rd_byte = y_coord_q[9:2];
      tpr_pkg::IDX_XY_LOW:
      begin
        rd_byte[tpr_pkg::LOW_TOUCH_BIT] = touch_raw_q;
        rd_byte[tpr_pkg::LOW_Y_LSB +: 2] = y_coord_q[1:0];
        rd_byte[tpr_pkg::LOW_X_LSB +: 2] = x_coord_q[1:0];
      end
      tpr_pkg::IDX_STATUS: rd_byte[tpr_pkg::STATUS_TOUCH_BIT] = manual && touch_raw_q;
      tpr_pkg::IDX_INT_EN: rd_byte = int_en_q;
      tpr_pkg::IDX_INT_STAT: rd_byte[tpr_pkg::INT_TOUCH_BIT] = touch_flag_q;
      default: rd_byte = 8'h00;
    endcase
    if (!mapped)
    begin
      rd_byte = 8'h00;
    end
  end

  // ==========================================================================
  // APB handshake
  // ==========================================================================
  // Every access waits one cycle; data and error are registered with pready.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // Writable registers
  // ==========================================================================
  // Software control registers update only on a completed write.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_ctrl_q <= tpr_pkg::ENABLE_CTRL_RST;
      mode_ctrl_q <= tpr_pkg::MODE_CTRL_RST;
      int_en_q <= tpr_pkg::INT_EN_RST;
    end
    else if (wr_en && mapped)
    begin
      case (idx)
        tpr_pkg::IDX_ENABLE_CTRL: enable_ctrl_q <= pwdata[7:0];
        tpr_pkg::IDX_MODE_CTRL: mode_ctrl_q <= pwdata[7:0];
        tpr_pkg::IDX_INT_EN: int_en_q <= pwdata[7:0];
        default: int_en_q <= int_en_q;
      endcase
    end
  end

  // ==========================================================================
  // Touch detect synchroniser and filter
  // ==========================================================================
  // Three stages; the level changes only once stages two and three agree.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      touch_raw_q <= 1'b0;
    end
    else
    begin
      sync1_q <= touch_detect_signal;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
      begin
        touch_raw_q <= sync3_q;
      end
    end
  end

  tpr_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clock(clock),
    .rst_n(rst_n),
    .level_in(touch_raw_q),
    .level_q(touch_deb)
  );

  // The filtered copy is used only when debouncing is switched on.
  assign touch_det = mode_ctrl_q[tpr_pkg::DEBOUNCE_EN_BIT] ? touch_deb : touch_raw_q;

  // ==========================================================================
  // Controller state machine
  // ==========================================================================
  assign auto_done = (conv_q == tpr_pkg::TPR_CV_DONE) && (last_state_q == state_q);

  // Next state: off forces idle, manual follows the field, auto runs alone.
  always_comb
  begin
    state_d = state_q;
    if (!active)
    begin
      state_d = tpr_pkg::TPR_IDLE;
    end
    else if (manual)
    begin
      state_d = tpr_pkg::tpr_state_t'(mode_ctrl_q[tpr_pkg::STATE_LSB +: 2]);
    end
    else
    begin
      case (state_q)
        tpr_pkg::TPR_IDLE: if (!touch_det) state_d = tpr_pkg::TPR_CHECK;
        tpr_pkg::TPR_CHECK: if (touch_det) state_d = tpr_pkg::TPR_LATCH_X;
        tpr_pkg::TPR_LATCH_X: if (auto_done) state_d = tpr_pkg::TPR_LATCH_Y;
        tpr_pkg::TPR_LATCH_Y: if (auto_done) state_d = tpr_pkg::TPR_IDLE;
        default: state_d = tpr_pkg::TPR_IDLE;
      endcase
    end
  end

  // State register and a copy that marks the first cycle of a new state.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= tpr_pkg::TPR_IDLE;
      last_state_q <= tpr_pkg::TPR_IDLE;
    end
    else
    begin
      state_q <= state_d;
      last_state_q <= state_q;
    end
  end

  // ==========================================================================
  // Conversion sequencing
  // ==========================================================================
  // Settle wait scales with the sample time field before each conversion.
  assign settle_load = 12'((32'(enable_ctrl_q[tpr_pkg::SETTLE_LSB +: 3]) + 32'd1) * SETTLE_CYCLES);

  // Each latch state settles, pulses start once and waits for done.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_q <= tpr_pkg::TPR_CV_SETTLE;
      settle_q <= 12'h000;
      adc_start_q <= 1'b0;
      adc_sel_y_q <= 1'b0;
    end
    else
    begin
      adc_start_q <= 1'b0;
      if (last_state_q != state_q)
      begin
        conv_q <= tpr_pkg::TPR_CV_SETTLE;
        settle_q <= settle_load;
        adc_sel_y_q <= (state_q == tpr_pkg::TPR_LATCH_Y);
      end
      else if ((state_q == tpr_pkg::TPR_LATCH_X) || (state_q == tpr_pkg::TPR_LATCH_Y))
      begin
        case (conv_q)
          tpr_pkg::TPR_CV_SETTLE:
          begin
            if (settle_q == 12'h000)
            begin
              adc_start_q <= 1'b1;
              conv_q <= tpr_pkg::TPR_CV_BUSY;
            end
            else
            begin
              settle_q <= settle_q - 12'h001;
            end
          end
          tpr_pkg::TPR_CV_BUSY: if (adc_done) conv_q <= tpr_pkg::TPR_CV_DONE;
          tpr_pkg::TPR_CV_DONE: conv_q <= tpr_pkg::TPR_CV_DONE;
          default: conv_q <= tpr_pkg::TPR_CV_SETTLE;
        endcase
      end
    end
  end

  assign adc_start = adc_start_q;
  assign adc_sel_y = adc_sel_y_q;

  // Coordinates change only on a done pulse of their own axis.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      x_coord_q <= tpr_pkg::COORD_RST;
      y_coord_q <= tpr_pkg::COORD_RST;
    end
    else if ((conv_q == tpr_pkg::TPR_CV_BUSY) && adc_done && (last_state_q == state_q))
    begin
      if (state_q == tpr_pkg::TPR_LATCH_X)
      begin
        x_coord_q <= adc_data;
      end
      else if (state_q == tpr_pkg::TPR_LATCH_Y)
      begin
        y_coord_q <= adc_data;
      end
    end
  end

  // ==========================================================================
  // Touch event flag and interrupt
  // ==========================================================================
  // Auto mode reports a touch once both axes are latched; manual mode
  // reports a touch rising while the checking state is selected.
  assign touch_event = active && (manual ?
      ((state_q == tpr_pkg::TPR_CHECK) && touch_det && !touch_det_prev_q) :
      ((state_q == tpr_pkg::TPR_LATCH_Y) && auto_done));

  // Clear by writing one to the flag bit or by reading the interrupt status word.
  assign flag_clear = access && mapped && (idx == tpr_pkg::IDX_INT_STAT) &&
      (!pwrite || pwdata[tpr_pkg::INT_TOUCH_BIT]);

  // Sticky flag: a new event wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      touch_flag_q <= 1'b0;
      touch_det_prev_q <= 1'b0;
    end
    else
    begin
      touch_det_prev_q <= touch_det;
      if (touch_event)
      begin
        touch_flag_q <= 1'b1;
      end
      else if (flag_clear)
      begin
        touch_flag_q <= 1'b0;
      end
    end
  end

  // Level interrupt while the flag is set and its enable bit is on.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= touch_flag_q && int_en_q[tpr_pkg::INT_TOUCH_EN_BIT];
    end
  end

  assign irq = irq_q;

endmodule

// [verification/tpr_panel_model.sv]
// Model of the ten-bit converter reading the resistive panel.
// Assumes the bench sets the two axis values and the answer delay.
`timescale 1ns/1ps
module tpr_panel_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Converter handshake
  input wire logic adc_start,
  input wire logic adc_sel_y,
  output logic adc_done,
  output logic [9:0] adc_data,
  // Panel position and answer delay
  input wire logic [9:0] x_val,
  input wire logic [9:0] y_val,
  input wire logic [7:0] adc_delay
);
  logic [7:0] cnt_q;
  logic sel_q;

  // =========================================================================
  // Conversion: data is only meaningful with done, and toggles otherwise.
  // =========================================================================
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      sel_q <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
    end
    else
    begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start)
      begin
        cnt_q <= adc_delay;
        sel_q <= adc_sel_y;
      end
      else if (cnt_q == 8'h01)
      begin
        cnt_q <= 8'h00;
        adc_done <= 1'b1;
        adc_data <= sel_q ? y_val : x_val;
      end
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// [verification/tpr_top_sva.sv]
// Port checker for the touch panel readout block.
// Assumes one clock domain; bound into every tpr_top instance.
`timescale 1ns/1ps
module tpr_top_sva #(
  parameter int unsigned DEBOUNCE_CYCLES = 4,
  parameter int unsigned SETTLE_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel side
  input wire logic touch_detect_signal,
  input wire logic adc_start,
  input wire logic adc_sel_y,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic busy_q;

  // =========================================================================
  // Helper: a conversion is outstanding from start until done.
  // =========================================================================
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busy_q <= 1'b0;
    else if (adc_start)
      busy_q <= 1'b1;
    else if (adc_done)
      busy_q <= 1'b0;
  end

  // Bus answers: timing, pulse width and data shape.
  property p_rdy_time; psel && $rose(penable) |-> ##1 pready; endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("pready late");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_cause; pready |-> $past(psel && penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready unasked");
  property p_err_pair; pslverr |-> pready; endproperty
  a_err_pair: assert property (p_err_pair) else $error("pslverr alone");
  property p_rd_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata idle");
  property p_mis; psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_mis: assert property (p_mis) else $error("misaligned accepted");
  // Converter handshake.
  property p_start_pulse; adc_start |=> !adc_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_one_conv; adc_start |-> !busy_q; endproperty
  a_one_conv: assert property (p_one_conv) else $error("start while busy");
  property p_sel_hold; $changed(adc_sel_y) |-> !busy_q; endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("axis moved");
  // The interrupt only drops after a register access clears or masks it.
  property p_irq_fall; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule

bind tpr_top tpr_top_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .touch_detect_signal(touch_detect_signal), .adc_start(adc_start), .adc_sel_y(adc_sel_y),
  .adc_done(adc_done), .adc_data(adc_data), .irq(irq));

// [verification/tpr_top_tb.sv]
// Self-checking bench for the touch panel readout block.
// Assumes the panel model and the bound port checker.
`timescale 1ns/1ps
module tpr_top_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic touch_detect_signal = 1'b0;
  logic adc_start;
  logic adc_sel_y;
  logic adc_done;
  logic [9:0] adc_data;
  logic irq;
  logic [9:0] x_v = 10'h2A5;
  logic [9:0] y_v = 10'h1C3;
  logic [7:0] dly = 8'h03;
  logic [1:0] addr_lo = 2'b00;
  logic [31:0] rd_v;
  logic err_v;
  int error_cnt = 0;
  int checks_done = 0;
  int starts_seen = 0;

  // =========================================================================
  // Clock, design and panel.
  // =========================================================================
  always #2 clock = ~clock;

  tpr_top #(.DEBOUNCE_CYCLES(4), .SETTLE_CYCLES(2)) u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touch_detect_signal(touch_detect_signal), .adc_start(adc_start),
    .adc_sel_y(adc_sel_y), .adc_done(adc_done), .adc_data(adc_data), .irq(irq));

  tpr_panel_model u_panel (.clock(clock), .rst_n(rst_n), .adc_start(adc_start), .adc_sel_y(adc_sel_y),
    .adc_done(adc_done), .adc_data(adc_data), .x_val(x_v), .y_val(y_v), .adc_delay(dly));

  // Counts conversions the design starts.
  always @(posedge clock)
    if (adc_start === 1'b1)
      starts_seen++;

  // =========================================================================
  // Shared tasks.
  // =========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  // One APB transfer; held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, addr_lo};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h000000, d});
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd_v, {24'h000000, exp});
  endtask

  // Waits, bounded, for the converter to answer.
  task automatic wait_done();
    int n;
    n = 0;
    @(posedge clock);
    while (adc_done !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(n < 300), 32'h1);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // =========================================================================
  // Scenarios.
  // =========================================================================
  task automatic t_reset();
    rdc(8'h70, 8'h00);
    rdc(8'h71, 8'h00);
    rdc(8'h72, 8'h00);
    rdc(8'hF0, 8'h00);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(err_v, 1'b1);
    check(rd_v, 32'h0000_0000);
    addr_lo = 2'b01;
    apb(1'b1, 8'h70, 32'h0000_00FF);
    addr_lo = 2'b00;
    check(err_v, 1'b1);
    rdc(8'h70, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_auto();
    int s;
    wr(8'hF0, 8'h00);
    wr(8'h71, 8'h04);
    wr(8'h70, 8'h80);
    s = starts_seen;
    touch_detect_signal <= 1'b1;
    repeat (2) @(posedge clock);
    touch_detect_signal <= 1'b0;
    repeat (40) @(posedge clock);
    check(starts_seen, s);
    touch_detect_signal <= 1'b1;
    wait_done();
    wait_done();
    repeat (4) @(posedge clock);
    check(irq, 1'b0);
    wr(8'hF0, 8'h40);
    repeat (3) @(posedge clock);
    check(irq, 1'b1);
    rdc(8'h72, x_v[9:2]);
    rdc(8'h73, y_v[9:2]);
    rdc(8'h74, {1'b1, 3'b000, y_v[1:0], x_v[1:0]});
    check(starts_seen, s + 2);
    touch_detect_signal <= 1'b0;
    repeat (20) @(posedge clock);
    rdc(8'hF1, 8'h04);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    rdc(8'hF1, 8'h00);
    rdc(8'h72, x_v[9:2]);
    $display("auto test done");
  endtask

  task automatic t_manual();
    x_v <= 10'h155;
    y_v <= 10'h3FE;
    dly <= 8'h14;
    wr(8'h70, 8'hB0);
    rdc(8'h70, 8'hB0);
    wr(8'h71, 8'h41);
    rdc(8'h75, 8'h00);
    touch_detect_signal <= 1'b1;
    repeat (10) @(posedge clock);
    repeat (3) rdc(8'h75, 8'h20);
    check(irq, 1'b1);
    wr(8'hF1, 8'h04);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    wr(8'h71, 8'h42);
    wait_done();
    check(adc_sel_y, 1'b0);
    wr(8'h71, 8'h43);
    wait_done();
    check(adc_sel_y, 1'b1);
    wr(8'h71, 8'h40);
    rdc(8'h72, x_v[9:2]);
    rdc(8'h73, y_v[9:2]);
    rdc(8'h74, {1'b1, 3'b000, y_v[1:0], x_v[1:0]});
    $display("manual test done");
  endtask

  task automatic t_disable();
    int s;
    wr(8'h70, 8'h00);
    wr(8'h71, 8'h00);
    touch_detect_signal <= 1'b0;
    repeat (10) @(posedge clock);
    s = starts_seen;
    touch_detect_signal <= 1'b1;
    repeat (60) @(posedge clock);
    check(starts_seen, s);
    rdc(8'hF1, 8'h00);
    $display("disable test done");
  endtask

  // Main sequence: reset for four cycles, then every scenario.
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_auto();
    t_manual();
    t_disable();
    close_out();
  end

  // Watchdog cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    close_out();
  end
endmodule
